// ### inc/rra_pkg.sv
// Shared constants and types of the round and rotate datapath slice
package rra_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OFS_OPERAND_EXT = 12'h000;
    localparam logic [11:0] OFS_OPERAND_HI  = 12'h004;
    localparam logic [11:0] OFS_OPERAND_LO  = 12'h008;
    localparam logic [11:0] OFS_MODE        = 12'h00C;
    localparam logic [11:0] OFS_COMMAND     = 12'h010;
    localparam logic [11:0] OFS_STATUS_WORD = 12'h014;
    localparam logic [11:0] OFS_LOOP_CNT    = 12'h018;
    localparam logic [11:0] OFS_ENGINE      = 12'h01C;

    // ****************************************
    // Status word bit positions
    // ****************************************
    localparam int SR_C  = 0;
    localparam int SR_V  = 1;
    localparam int SR_Z  = 2;
    localparam int SR_N  = 3;
    localparam int SR_E  = 5;
    localparam int SR_L  = 6;
    localparam int SR_LF = 15;

    // ****************************************
    // Mode register bit positions
    // ****************************************
    localparam int MODE_RND_TWOS  = 0;
    localparam int MODE_CC_WIDTH  = 1;
    localparam int MODE_SAT_EN    = 2;

    // ****************************************
    // Command fields
    // ****************************************
    localparam int CMD_OP_LSB     = 0;
    localparam int CMD_DST_ACC    = 4;
    localparam int CMD_SRC_IMM    = 5;
    localparam int CMD_SRC_SAT    = 6;
    localparam int CMD_MV_LSB     = 8;
    localparam int CMD_MV_W       = 4;
    localparam int CMD_LIMIT_MV   = 12;
    localparam int CMD_IMM_LSB    = 16;

    // ****************************************
    // Widths, reset values and cycle counts
    // ****************************************
    localparam int LOOP_W        = 13;
    localparam int IMM_W         = 6;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [2:0]  MODE_RESET   = 3'h0;
    localparam int RND_CYCLES    = 2;
    localparam int ROT_CYCLES    = 2;
    localparam int REP_CYCLES    = 6;

    typedef enum logic [2:0] {
        OP_NONE, OP_ROUND, OP_ROL, OP_ROR, OP_REPEAT
    } rra_op_e;

endpackage

// ### design/rra_apb_slave.sv
// APB slave decode for the round and rotate slice
`timescale 1ns/100ps
module rra_apb_slave (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic        engine_busy,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic             pready_nxt,
    output logic             pslverr_nxt
);
    // ****************************************
    // Decode
    // ****************************************
    wire access_w = psel && penable;
    wire mapped_w = (paddr[1:0] == 2'b00) &&
                    (paddr <= rra_pkg::OFS_ENGINE);
    // Command writes stall while the engine is busy, giving back-pressure
    wire stall_w  = pwrite && engine_busy &&
                    (paddr == rra_pkg::OFS_COMMAND);
    logic done_r;

    always_ff @(posedge clk) begin
        if (srst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= access_w && !stall_w && !done_r;
        end
    end

    // One wait state, answer on the second access edge
    assign pready_nxt  = access_w && !stall_w && !done_r;
    assign pslverr_nxt = pready_nxt && !mapped_w;
    assign wr_stb      = pready_nxt && mapped_w && pwrite;
    assign rd_stb      = pready_nxt && mapped_w && !pwrite;
endmodule

// ### design/rra_flag_calc.sv
// Result and flag computation of the round and rotate operations
`timescale 1ns/100ps
module rra_flag_calc (
    input  wire logic [2:0]  op,
    input  wire logic [35:0] acc_in,
    input  wire logic        dst_acc,
    input  wire logic        rnd_twos,
    input  wire logic        cc_width,
    input  wire logic        limit_mv,
    input  wire logic [15:0] sr_in,
    output logic [35:0]      acc_out,
    output logic [15:0]      sr_out
);
    // ****************************************
    // Rounding and rotation
    // ****************************************
    logic [36:0] sum_w;
    logic [35:0] rnd_w;
    logic        half_w;
    logic        ovf_w;
    logic [15:0] word_w;
    logic [15:0] rot_w;
    logic        c_new;

    always_comb begin
        sum_w  = {acc_in[35], acc_in} + 37'h0_0000_8000;
        half_w = (acc_in[15:0] == 16'h8000);
        rnd_w  = {sum_w[35:16], 16'h0000};
        if (!rnd_twos && half_w) begin
            rnd_w[16] = 1'b0;
        end
        ovf_w  = sum_w[36] ^ sum_w[35];
        word_w = dst_acc ? acc_in[31:16] : acc_in[15:0];
        rot_w  = 16'h0000;
        c_new  = sr_in[rra_pkg::SR_C];
        acc_out = acc_in;
        sr_out  = sr_in;
        if (op == 3'(rra_pkg::OP_ROUND)) begin
            acc_out = dst_acc ? rnd_w : {rnd_w[35:16], acc_in[15:0]};
            sr_out[rra_pkg::SR_N] = rnd_w[35];
            sr_out[rra_pkg::SR_Z] = (rnd_w == 36'h0_0000_0000);
            sr_out[rra_pkg::SR_V] = ovf_w;
            sr_out[rra_pkg::SR_L] = limit_mv | ovf_w;
            sr_out[rra_pkg::SR_E] = (rnd_w[35:31] != 5'h00) &&
                                    (rnd_w[35:31] != 5'h1F);
            if (cc_width) begin
                sr_out[rra_pkg::SR_N] = rnd_w[31];
                sr_out[rra_pkg::SR_Z] = (rnd_w[31:0] == 32'h0000_0000);
            end
        end else if (op == 3'(rra_pkg::OP_ROL) ||
                     op == 3'(rra_pkg::OP_ROR)) begin
            if (op == 3'(rra_pkg::OP_ROL)) begin
                rot_w = {word_w[14:0], sr_in[rra_pkg::SR_C]};
                c_new = word_w[15];
            end else begin
                rot_w = {sr_in[rra_pkg::SR_C], word_w[15:1]};
                c_new = word_w[0];
            end
            acc_out = dst_acc ? {acc_in[35:32], rot_w, acc_in[15:0]}
                              : {acc_in[35:16], rot_w};
            sr_out[rra_pkg::SR_C] = c_new;
            sr_out[rra_pkg::SR_N] = rot_w[15];
            sr_out[rra_pkg::SR_Z] = (rot_w == 16'h0000);
            sr_out[rra_pkg::SR_V] = 1'b0;
        end
    end
endmodule

// ### design/rra_top.sv
// Round, rotate and repeat datapath slice with APB register access
`timescale 1ns/100ps
module rra_top (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             REPEAT_STEP,
    output logic             SKIP_NEXT,
    output logic             IRQ_HOLD,
    output logic             BUSY
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_LOOP} rra_state_e;

    rra_state_e  state_r;
    logic [35:0] acc_r;
    logic [15:0] sr_r;
    logic [2:0]  mode_r;
    logic [31:0] cmd_r;
    logic [12:0] lc_r;
    logic [12:0] lc_save_r;
    logic [7:0]  cyc_r;
    logic [35:0] acc_calc;
    logic [15:0] sr_calc;
    logic        wr_stb;
    logic        rd_stb;
    logic        pready_nxt;
    logic        pslverr_nxt;

    rra_apb_slave u_apb (
        .clk         (CLK),
        .srst        (SRST),
        .psel        (PSEL),
        .penable     (PENABLE),
        .pwrite      (PWRITE),
        .paddr       (PADDR),
        .engine_busy (state_r != ST_IDLE),
        .wr_stb      (wr_stb),
        .rd_stb      (rd_stb),
        .pready_nxt  (pready_nxt),
        .pslverr_nxt (pslverr_nxt)
    );

    // ****************************************
    // Command decode
    // ****************************************
    wire [2:0] op_w      = cmd_r[rra_pkg::CMD_OP_LSB +: 3];
    wire       dst_acc_w = cmd_r[rra_pkg::CMD_DST_ACC];
    wire [3:0] mv_w      = cmd_r[rra_pkg::CMD_MV_LSB +: rra_pkg::CMD_MV_W];
    wire       cmd_wr_w  = wr_stb && (PADDR == rra_pkg::OFS_COMMAND);
    wire [2:0] new_op_w  = PWDATA[rra_pkg::CMD_OP_LSB +: 3];
    wire       is_rep_w  = (op_w == 3'(rra_pkg::OP_REPEAT));

    rra_flag_calc u_calc (
        .op       (op_w),
        .acc_in   (acc_r),
        .dst_acc  (dst_acc_w),
        .rnd_twos (mode_r[rra_pkg::MODE_RND_TWOS]),
        .cc_width (mode_r[rra_pkg::MODE_CC_WIDTH]),
        .limit_mv (cmd_r[rra_pkg::CMD_LIMIT_MV]),
        .sr_in    (sr_r),
        .acc_out  (acc_calc),
        .sr_out   (sr_calc)
    );

    // Cycle budget of the running operation
    function automatic logic [7:0] op_cycles(input logic [2:0] op,
                                             input logic [3:0] mv);
        if (op == 3'(rra_pkg::OP_ROUND)) begin
            op_cycles = 8'(rra_pkg::RND_CYCLES) + {4'h0, mv};
        end else if (op == 3'(rra_pkg::OP_REPEAT)) begin
            op_cycles = 8'(rra_pkg::REP_CYCLES);
        end else begin
            op_cycles = 8'(rra_pkg::ROT_CYCLES);
        end
    endfunction

    // ****************************************
    // Repeat count source
    // ****************************************
    // immediate count
    wire [12:0] imm_cnt_w = {7'h00,
        PWDATA[rra_pkg::CMD_IMM_LSB +: rra_pkg::IMM_W]};
    // Register count: 13 bits of the supplied word from bit CMD_IMM_LSB up
    wire [12:0] reg_cnt_w = PWDATA[rra_pkg::CMD_IMM_LSB +: 13];
    wire [12:0] rep_cnt_w = PWDATA[rra_pkg::CMD_SRC_IMM] ? imm_cnt_w
                                                         : reg_cnt_w;
    wire        start_w   = cmd_wr_w && (new_op_w != 3'(rra_pkg::OP_NONE));
    wire        last_w    = (cyc_r == 8'h01);

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_r   <= ST_IDLE;
            cmd_r     <= 32'h0000_0000;
            cyc_r     <= 8'h00;
            lc_r      <= 13'h0000;
            lc_save_r <= 13'h0000;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_w) begin
                        state_r <= ST_EXEC;
                        cmd_r   <= PWDATA;
                        cyc_r   <= op_cycles(new_op_w,
                            PWDATA[rra_pkg::CMD_MV_LSB +: rra_pkg::CMD_MV_W]);
                        if (new_op_w == 3'(rra_pkg::OP_REPEAT)) begin
                            lc_save_r <= lc_r;
                            lc_r      <= rep_cnt_w;
                        end
                    end else if (wr_stb &&
                                 PADDR == rra_pkg::OFS_LOOP_CNT) begin
                        lc_r <= PWDATA[12:0];
                    end
                end
                ST_EXEC: begin
                    cyc_r <= cyc_r - 8'h01;
                    if (last_w) begin
                        state_r <= (is_rep_w && lc_r != 13'h0000)
                                   ? ST_LOOP : ST_IDLE;
                        if (is_rep_w && lc_r == 13'h0000) begin
                            lc_r <= lc_save_r;
                        end
                    end
                end
                ST_LOOP: begin
                    // run until counter is one, then restore
                    if (lc_r == 13'h0001) begin
                        lc_r    <= lc_save_r;
                        state_r <= ST_IDLE;
                    end else begin
                        lc_r <= lc_r - 13'h0001;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Datapath registers
    // ****************************************
    wire exec_end_w = (state_r == ST_EXEC) && last_w;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            acc_r  <= 36'h0_0000_0000;
            sr_r   <= rra_pkg::STATUS_RESET;
            mode_r <= rra_pkg::MODE_RESET;
        end else begin
            if (exec_end_w && !is_rep_w) begin
                acc_r <= acc_calc;
                sr_r  <= sr_calc;
            end else if (exec_end_w) begin
                sr_r[rra_pkg::SR_L] <= sr_r[rra_pkg::SR_L] |
                    (!cmd_r[rra_pkg::CMD_SRC_IMM] &&
                     cmd_r[rra_pkg::CMD_SRC_SAT]);
            end else if (wr_stb && state_r == ST_IDLE) begin
                if (PADDR == rra_pkg::OFS_OPERAND_EXT) begin
                    acc_r[35:32] <= PWDATA[3:0];
                end
                if (PADDR == rra_pkg::OFS_OPERAND_HI) begin
                    acc_r[31:16] <= PWDATA[15:0];
                end
                if (PADDR == rra_pkg::OFS_OPERAND_LO) begin
                    acc_r[15:0] <= PWDATA[15:0];
                end
                if (PADDR == rra_pkg::OFS_STATUS_WORD) begin
                    sr_r <= PWDATA[15:0];
                end
            end
            if (wr_stb && PADDR == rra_pkg::OFS_MODE) begin
                mode_r <= PWDATA[2:0];
            end
        end
    end

    // ****************************************
    // Read mux and registered outputs
    // ****************************************
    logic [31:0] rd_mux;
    always_comb begin
        unique case (PADDR)
            rra_pkg::OFS_OPERAND_EXT: rd_mux = {28'h000_0000, acc_r[35:32]};
            rra_pkg::OFS_OPERAND_HI:  rd_mux = {16'h0000, acc_r[31:16]};
            rra_pkg::OFS_OPERAND_LO:  rd_mux = {16'h0000, acc_r[15:0]};
            rra_pkg::OFS_MODE:        rd_mux = {29'h0000_0000, mode_r};
            rra_pkg::OFS_COMMAND:     rd_mux = cmd_r;
            rra_pkg::OFS_STATUS_WORD: rd_mux = {16'h0000,
                state_r == ST_LOOP, sr_r[14:0]};
            rra_pkg::OFS_LOOP_CNT:    rd_mux = {19'h0_0000, lc_r};
            rra_pkg::OFS_ENGINE:      rd_mux = {22'h00_0000, state_r, cyc_r};
            default:                  rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            PRDATA      <= 32'h0000_0000;
            PREADY      <= 1'b0;
            PSLVERR     <= 1'b0;
            REPEAT_STEP <= 1'b0;
            SKIP_NEXT   <= 1'b0;
            IRQ_HOLD    <= 1'b0;
            BUSY        <= 1'b0;
        end else begin
            PRDATA  <= rd_stb ? rd_mux : 32'h0000_0000;
            PREADY  <= pready_nxt;
            PSLVERR <= pslverr_nxt;
            REPEAT_STEP <= (state_r == ST_LOOP);
            IRQ_HOLD    <= (state_r != ST_IDLE) && is_rep_w;
            SKIP_NEXT   <= exec_end_w && is_rep_w && lc_r == 13'h0000;
            BUSY        <= (state_r != ST_IDLE);
        end
    end
endmodule

// ### tb/rra_assertions.sv
// Port-level checks of the round and rotate slice
`timescale 1ns/100ps
module rra_assertions (
    input wire logic        CLK,
    input wire logic        SRST,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        REPEAT_STEP,
    input wire logic        SKIP_NEXT,
    input wire logic        IRQ_HOLD,
    input wire logic        BUSY
);
    // ********
    // Decode
    // ********
    wire logic       cmd_done = PREADY && PWRITE && !PSLVERR &&
                                PADDR == rra_pkg::OFS_COMMAND;
    wire logic [2:0] cmd_op   = PWDATA[2:0];
    wire logic       is_rot   = cmd_op == 3'h2 || cmd_op == 3'h3;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // ********
    // Checks
    // ********
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("Ready longer than one cycle");
    ready_access_a: assert property (PREADY |-> PSEL && PENABLE &&
        $past(PENABLE)) else $error("Ready outside an access phase");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("Error without ready");
    bad_addr_a: assert property (PREADY && (PADDR[1:0] != 2'h0 ||
        PADDR > rra_pkg::OFS_ENGINE) |-> PSLVERR)
        else $error("Unmapped access not flagged");
    reset_idle_a: assert property ($fell(SRST) |-> !BUSY && !IRQ_HOLD &&
        !PREADY) else $error("Outputs active after reset");
    cmd_start_a: assert property (cmd_done && cmd_op inside {[3'h1:3'h4]}
        |-> ##[0:2] BUSY) else $error("Command did not start");
    round_len_a: assert property (cmd_done && cmd_op == 3'h1
        |-> ##[0:2] BUSY ##[1:20] !BUSY) else $error("Round too long");
    rotate_len_a: assert property (cmd_done && is_rot
        |-> ##[0:2] BUSY ##[1:4] !BUSY) else $error("Rotate too long");
    skip_alone_a: assert property (SKIP_NEXT |-> !REPEAT_STEP
        ##1 !SKIP_NEXT) else $error("Skip mixed with a step");
    step_hold_a: assert property (REPEAT_STEP |-> IRQ_HOLD)
        else $error("Step without interrupt hold");

    cover property (SKIP_NEXT);
    cover property (REPEAT_STEP ##1 !REPEAT_STEP);
    cover property (PSLVERR);
endmodule

// ### tb/rra_ctrl_model.sv
// Program controller model issuing bus accesses to the slice
`timescale 1ns/100ps
module rra_ctrl_model (
    input  wire logic        CLK,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR,
    output logic             PSEL,
    output logic             PENABLE,
    output logic             PWRITE,
    output logic      [11:0] PADDR,
    output logic      [31:0] PWDATA
);
    initial begin
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0000_0000;
    end

    // ********
    // Bus access
    // ********
    // data-field counts only
    // Loop counts travel in the command word, so no control register
    // is ever named as a source and no read targets the destination
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        // No wait-state count assumed; the bench watchdog ends a hang
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the round and rotate slice
`timescale 1ns/100ps
module tb_top;
    logic        CLK;
    logic        SRST;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        REPEAT_STEP;
    logic        SKIP_NEXT;
    logic        IRQ_HOLD;
    logic        BUSY;
    int          fail_count;
    int          samples_checked;
    logic [35:0] bc;
    logic [35:0] st;
    logic [35:0] sk;
    logic [35:0] ih;
    logic [35:0] t0;
    logic [31:0] q;
    logic        e;

    always #5 CLK = ~CLK;

    rra_top i_dut (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .REPEAT_STEP(REPEAT_STEP),
        .SKIP_NEXT(SKIP_NEXT), .IRQ_HOLD(IRQ_HOLD), .BUSY(BUSY));
    rra_ctrl_model i_ctrl (.CLK(CLK), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA));

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        i_ctrl.xfer(1'b1, a, d, r, x);
    endtask

    task automatic rd(input logic [11:0] a);
        i_ctrl.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask

    // Waits for idle; sampling at the edge sees every busy cycle
    task automatic go(input logic [31:0] cmd);
        logic seen;
        seen = 1'b0;
        bc = 36'h0;
        st = 36'h0;
        sk = 36'h0;
        ih = 36'h0;
        wr(rra_pkg::OFS_COMMAND, cmd);
        for (int k = 0; k < 400; k++) begin
            @(posedge CLK);
            if (BUSY === 1'b1) bc = bc + 36'h1;
            if (IRQ_HOLD === 1'b1) ih = ih + 36'h1;
            if (REPEAT_STEP === 1'b1) st = st + 36'h1;
            if (SKIP_NEXT === 1'b1) sk = sk + 36'h1;
            if (BUSY === 1'b1) seen = 1'b1;
            if (seen && BUSY !== 1'b1 && IRQ_HOLD !== 1'b1 &&
                REPEAT_STEP !== 1'b1) break;
        end
    endtask

    task automatic oc(input logic [2:0] m, input logic [15:0] c,
                      input logic [35:0] a, input logic [1:0] f,
                      input logic [35:0] x, input logic [7:0] s);
        logic [35:0] r;
        wr(rra_pkg::OFS_MODE, {29'h0, m});
        wr(rra_pkg::OFS_OPERAND_EXT, {28'h0, a[35:32]});
        wr(rra_pkg::OFS_OPERAND_HI, {16'h0, a[31:16]});
        wr(rra_pkg::OFS_OPERAND_LO, {16'h0, a[15:0]});
        wr(rra_pkg::OFS_STATUS_WORD, {30'h0, f});
        go({16'h0, c});
        rd(rra_pkg::OFS_OPERAND_EXT);
        r[35:32] = q[3:0];
        rd(rra_pkg::OFS_OPERAND_HI);
        r[31:16] = q[15:0];
        rd(rra_pkg::OFS_OPERAND_LO);
        r[15:0] = q[15:0];
        chk(r, x);
        rd(rra_pkg::OFS_STATUS_WORD);
        chk({4'h0, q & 32'h0000_006F}, {28'h0, s});
    endtask

    task automatic rp(input logic [31:0] c, input logic [35:0] n,
                      input logic k, input logic [7:0] s);
        wr(rra_pkg::OFS_LOOP_CNT, 32'h0000_00A5);
        wr(rra_pkg::OFS_STATUS_WORD, 32'h0000_0001);
        go(c);
        chk(st, n);
        chk(sk, {35'h0, k});
        chk(bc, n + 36'(rra_pkg::REP_CYCLES));
        chk(ih, n + 36'(rra_pkg::REP_CYCLES));
        rd(rra_pkg::OFS_LOOP_CNT);
        chk(q, 36'h0_00A5);
        rd(rra_pkg::OFS_STATUS_WORD);
        chk(q & 32'h0000_006F, s);
    endtask

    task final_report;
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ********
    // Tests
    // ********
    initial begin
        CLK = 1'b0;
        SRST = 1'b1;
        fail_count = 0;
        samples_checked = 0;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        rd(rra_pkg::OFS_STATUS_WORD);
        chk(q, 36'h0);
        rd(rra_pkg::OFS_MODE);
        chk(q, 36'h0);
        rd(12'h020);
        chk(e, 36'h1);
        rd(12'h006);
        chk(e, 36'h1);
        $display("Test reset and decode done");
        oc(3'h0,16'h0011,36'h0_1236_8000,2'h0,36'h0_1236_0000,8'h00);
        oc(3'h1,16'h0011,36'h0_1236_8000,2'h0,36'h0_1237_0000,8'h00);
        oc(3'h0,16'h0011,36'h0_1235_8000,2'h1,36'h0_1236_0000,8'h01);
        oc(3'h0,16'h0011,36'h5_1236_789A,2'h0,36'h5_1236_0000,8'h20);
        oc(3'h1,16'h0011,36'h0_7FFF_8000,2'h0,36'h0_8000_0000,8'h20);
        oc(3'h3,16'h0011,36'h0_7FFF_8000,2'h0,36'h0_8000_0000,8'h28);
        oc(3'h2,16'h0011,36'hF_0000_0000,2'h0,36'hF_0000_0000,8'h24);
        oc(3'h0,16'h0011,36'h0_0000_4000,2'h0,36'h0_0000_0000,8'h04);
        oc(3'h1,16'h0011,36'h7_FFFF_8000,2'h0,36'h8_0000_0000,8'h6A);
        oc(3'h0,16'h1011,36'h0_1236_0000,2'h0,36'h0_1236_0000,8'h40);
        $display("Test rounding done");
        oc(3'h0,16'h0012,36'hF_0001_00AA,2'h0,36'hF_0002_00AA,8'h00);
        oc(3'h4,16'h0012,36'h3_8000_1234,2'h1,36'h3_0001_1234,8'h01);
        oc(3'h0,16'h0012,36'h3_8000_1234,2'h0,36'h3_0000_1234,8'h05);
        oc(3'h0,16'h0002,36'h0_0000_FFFF,2'h2,36'h0_0000_FFFE,8'h09);
        oc(3'h0,16'h0013,36'hF_0001_00AA,2'h0,36'hF_0000_00AA,8'h05);
        oc(3'h4,16'h0013,36'hF_0002_00AA,2'h3,36'hF_8001_00AA,8'h08);
        oc(3'h0,16'h0003,36'h0_1234_0001,2'h3,36'h0_1234_8000,8'h09);
        $display("Test rotates done");
        wr(rra_pkg::OFS_MODE, 32'h0000_0007);
        SRST <= 1'b1;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        rd(rra_pkg::OFS_MODE);
        chk(q, 36'h0);
        $display("Test mid-run reset done");
        oc(3'h0,16'h0011,36'h0_1236_0000,2'h0,36'h0_1236_0000,8'h00);
        t0 = bc;
        chk(t0, 36'(rra_pkg::RND_CYCLES));
        oc(3'h0,16'h0311,36'h0_1236_0000,2'h0,36'h0_1236_0000,8'h00);
        chk(bc, t0 + 36'h3);
        oc(3'h0,16'h0012,36'h0_1236_0000,2'h0,36'h0_246C_0000,8'h00);
        chk(bc, t0);
        $display("Test timing done");
        rp(32'h0003_0024, 36'h3, 1'b0, 8'h01);
        rp(32'h0043_0024, 36'h3, 1'b0, 8'h01);
        rp(32'h003F_0024, 36'h3F, 1'b0, 8'h01);
        rp(32'h0000_0024, 36'h0, 1'b1, 8'h01);
        rp(32'h2005_0004, 36'h5, 1'b0, 8'h01);
        rp(32'h0004_0044, 36'h4, 1'b0, 8'h41);
        $display("Test repeat done");
        final_report();
    end

    // Whole run needs just over a thousand cycles; this bound catches a hang
    initial begin
        repeat (20000) @(posedge CLK);
        fail_count++;
        final_report();
    end
endmodule

bind rra_top rra_assertions i_chk (.CLK(CLK), .SRST(SRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .REPEAT_STEP(REPEAT_STEP), .SKIP_NEXT(SKIP_NEXT),
    .IRQ_HOLD(IRQ_HOLD), .BUSY(BUSY));
